// file: comparator_pkg.sv
// package with register map, field positions and carrier types of the comparator control block
// Notes on behaviour
// RULE1: control bit 0 enables; register resets zero
// RULE2: standby run bit keeps comparator alive
// RULE3: stopped clock in standby freezes status, irq; a write of one still clears the flag
// RULE4: pad enable bit drives output onto pin
// RULE5: edge mode: 0 any, 2 fall, 3 rise
// RULE6: hysteresis field passed to analog core
// RULE7: invert bit flips output for all consumers
// RULE8: bit 3 picks positive input pin
// RULE9: bits 1:0 pick negative input source
// RULE10: irq enable bit gates interrupt request
// RULE11: state bit through three-cycle synchronizer
// RULE12: flag cleared by writing one
// RULE13: selected edge sets the interrupt flag
// RULE14: request holds while flag and enable set
// RULE15: raw high means positive exceeds negative
// RULE16: power-down disables comparator and pad
// RULE17: reserved offsets and bits read zero
// RULE18: edges found on synchronized sampled output
package comparator_pkg;
   // ===================================================
   // register indices (printed offsets), byte address is four times index
   localparam logic [2:0] IDX_CONTROL = 3'h0;
   localparam logic [2:0] IDX_INSEL = 3'h2;
   localparam logic [2:0] IDX_IRQEN = 3'h6;
   localparam logic [2:0] IDX_STATUS = 3'h7;
   localparam int ADDR_W = 5;
   localparam logic [7:0] RESET_VAL = 8'h00;
   // ===================================================
   // field positions
   localparam int CTL_ENABLE = 0;
   localparam int CTL_HYS_LO = 1;
   localparam int CTL_MODE_LO = 4;
   localparam int CTL_PADEN = 6;
   localparam int CTL_STBYRUN = 7;
   localparam int SEL_NEG_LO = 0;
   localparam int SEL_POS = 3;
   localparam int SEL_INVERT = 7;
   localparam int IRQ_CMP = 0;
   localparam int ST_FLAG = 0;
   localparam int ST_STATE = 4;
   localparam int SYNC_STAGES = 3;
   // writable masks keep unused bits at zero
   localparam logic [7:0] CTL_MASK = 8'hF7;
   localparam logic [7:0] SEL_MASK = 8'h8B;
   localparam logic [7:0] IRQ_MASK = 8'h01;
   // ===================================================
   // edge modes
   typedef enum logic [1:0] {
      MODE_ANY = 2'h0,
      MODE_RSVD = 2'h1,
      MODE_FALL = 2'h2,
      MODE_RISE = 2'h3
   } edge_mode_e;
   // power modes from the sleep controller
   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'h0,
      PWR_STANDBY = 2'h1,
      PWR_DOWN = 2'h2
   } power_mode_e;
   // analog core controls
   typedef struct packed {
      logic enable;
      logic [1:0] hysteresis;
      logic posSel;
      logic [1:0] negSel;
   } analog_ctl_s;
endpackage

// file: comparator_control_regs.sv
// apb register bank and digital control around the voltage comparator
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
module comparator_control_regs
   import comparator_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [comparator_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog core and sleep controller
   input wire logic rawCompare,
   input wire comparator_pkg::power_mode_e powerMode,
   input wire logic perClkStopped,
   output comparator_pkg::analog_ctl_s analogCtl,
   // pad and event outputs
   output logic padOut,
   output logic padOe_n,
   output logic compareEvent,
   output logic irq
);
   import comparator_pkg::*;

   // ===================================================
   // register state
   logic [7:0] ctl_r, ctl_nxt;
   logic [7:0] sel_r, sel_nxt;
   logic [7:0] irqEn_r, irqEn_nxt;
   logic flag_r, flag_nxt;
   logic [SYNC_STAGES-1:0] sync_r, sync_nxt;
   logic prevState_r, prevState_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic pready_r, pready_nxt;
   logic irq_r, irq_nxt;
   logic padOut_r, padOut_nxt, padOe_r, padOe_nxt, evt_r, evt_nxt;
   analog_ctl_s ana_r, ana_nxt;

   logic wrEn, rdEn, compRun, unfrozen, polOut, edgeHit, curState;
   logic [2:0] idx;
   edge_mode_e mode;

   // apb access completes in the access phase with zero wait states
   assign idx = paddr[ADDR_W-1:2];
   assign wrEn = psel && penable && pwrite && pstrb[0];
   assign rdEn = psel && !penable && !pwrite;
   assign mode = edge_mode_e'(ctl_r[CTL_MODE_LO +: 2]);

   // comparator runs when enabled and not halted by sleep
   assign compRun = ctl_r[CTL_ENABLE] && (powerMode == PWR_ACTIVE ||                  // see RULE1
      (powerMode == PWR_STANDBY && ctl_r[CTL_STBYRUN]));                             // see RULE2 see RULE16
   // without peripheral clock in standby the synchronizer, previous sample and request hold, and the flag holds unless a write of one clears it
   assign unfrozen = !(powerMode == PWR_STANDBY && perClkStopped);                   // see RULE3
   // raw high means positive above negative, invert for all consumers
   assign polOut = rawCompare ^ sel_r[SEL_INVERT];                                   // see RULE15 see RULE7
   assign curState = sync_r[SYNC_STAGES-1];
   // edge on synchronized value against previous sample
   always_comb begin
      case (mode)
         MODE_ANY: edgeHit = curState != prevState_r;                                // see RULE5 see RULE18
         MODE_FALL: edgeHit = prevState_r && !curState;
         MODE_RISE: edgeHit = !prevState_r && curState;
         default: edgeHit = 1'b0;                                                    // reserved code never fires
      endcase
   end

   // ===================================================
   // next-state logic for registers and status
   always_comb begin
      ctl_nxt = ctl_r;
      sel_nxt = sel_r;
      irqEn_nxt = irqEn_r;
      if (wrEn && idx == IDX_CONTROL) ctl_nxt = pwdata[7:0] & CTL_MASK;             // see RULE17
      if (wrEn && idx == IDX_INSEL) sel_nxt = pwdata[7:0] & SEL_MASK;
      if (wrEn && idx == IDX_IRQEN) irqEn_nxt = pwdata[7:0] & IRQ_MASK;
      // synchronizer shifts whenever not frozen, taking zero while halted; first stage read only by second
      sync_nxt = sync_r;
      prevState_nxt = prevState_r;
      if (unfrozen) begin
         sync_nxt = {sync_r[SYNC_STAGES-2:0], compRun & polOut};                    // see RULE11
         prevState_nxt = curState;
      end
      // set beats clear so no edge is lost
      flag_nxt = flag_r;
      if (wrEn && idx == IDX_STATUS && pwdata[ST_FLAG]) flag_nxt = 1'b0;             // see RULE12
      if (unfrozen && compRun && edgeHit) flag_nxt = 1'b1;                           // see RULE13
      irq_nxt = irq_r;
      if (unfrozen) irq_nxt = flag_nxt && irqEn_nxt[IRQ_CMP];                        // see RULE10 see RULE14
      // read data captured in setup so it is ready at the access edge
      prdata_nxt = prdata_r;
      if (rdEn) begin
         prdata_nxt = 32'h0000_0000;
         case (idx)
            IDX_CONTROL: prdata_nxt[7:0] = ctl_r;
            IDX_INSEL: prdata_nxt[7:0] = sel_r;
            IDX_IRQEN: prdata_nxt[7:0] = irqEn_r;
            IDX_STATUS: begin
               prdata_nxt[ST_STATE] = curState;
               prdata_nxt[ST_FLAG] = flag_r;
            end
            default: prdata_nxt = 32'h0000_0000;                                     // see RULE17
         endcase
      end
      pready_nxt = psel && !penable;
      // pad and event follow the comparator even in standby
      padOut_nxt = compRun & polOut;
      padOe_nxt = !(compRun && ctl_r[CTL_PADEN]);                                    // see RULE4 see RULE16
      evt_nxt = compRun & polOut;
      ana_nxt.enable = compRun;
      ana_nxt.hysteresis = ctl_r[CTL_HYS_LO +: 2];                                   // see RULE6
      ana_nxt.posSel = sel_r[SEL_POS];                                               // see RULE8
      ana_nxt.negSel = sel_r[SEL_NEG_LO +: 2];                                       // see RULE9
   end

   // registers only
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         ctl_r <= RESET_VAL;
         sel_r <= RESET_VAL;
         irqEn_r <= RESET_VAL;
         flag_r <= 1'b0;
         sync_r <= '0;
         prevState_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pready_r <= 1'b0;
         irq_r <= 1'b0;
         padOut_r <= 1'b0;
         padOe_r <= 1'b1;
         evt_r <= 1'b0;
         ana_r <= '0;
      end else begin
         ctl_r <= ctl_nxt;
         sel_r <= sel_nxt;
         irqEn_r <= irqEn_nxt;
         flag_r <= flag_nxt;
         sync_r <= sync_nxt;
         prevState_r <= prevState_nxt;
         prdata_r <= prdata_nxt;
         pready_r <= pready_nxt;
         irq_r <= irq_nxt;
         padOut_r <= padOut_nxt;
         padOe_r <= padOe_nxt;
         evt_r <= evt_nxt;
         ana_r <= ana_nxt;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = 1'b0;
   assign irq = irq_r;
   assign padOut = padOut_r;
   assign padOe_n = padOe_r;
   assign compareEvent = evt_r;
   assign analogCtl = ana_r;

   // ===================================================
   // checks
   chk_reset_ctl: assert property (@(posedge core_clk) $rose(arst_n) |-> ctl_r == RESET_VAL) // see RULE1
      else $error("control not zero after reset");
   chk_standby_halt: assert property (@(posedge core_clk) disable iff (!arst_n)
      (powerMode == PWR_STANDBY && !ctl_r[CTL_STBYRUN]) |=> !analogCtl.enable)   // see RULE2
      else $error("comparator runs in standby without run bit");
   chk_frozen_flag: assert property (@(posedge core_clk) disable iff (!arst_n)
      (!unfrozen && !wrEn) |=> $stable(flag_r) && $stable(irq))                  // see RULE3
      else $error("status moved with clock stopped");
   chk_pad_off: assert property (@(posedge core_clk) disable iff (!arst_n)
      !ctl_r[CTL_PADEN] |=> padOe_n)                                             // see RULE4
      else $error("pad driven while disabled");
   chk_rise_only: assert property (@(posedge core_clk) disable iff (!arst_n)
      (mode == MODE_RISE && prevState_r && !curState && !flag_r) |=> !flag_r)    // see RULE5
      else $error("falling edge set flag in rise mode");
   chk_hys_pass: assert property (@(posedge core_clk) disable iff (!arst_n)
      1'b1 |=> analogCtl.hysteresis == $past(ctl_r[CTL_HYS_LO +: 2]))            // see RULE6
      else $error("hysteresis not presented");
   chk_sync_delay: assert property (@(posedge core_clk) disable iff (!arst_n)
      (unfrozen && compRun)[*4] |-> curState == $past(polOut, 3))                // see RULE11 see RULE7
      else $error("state bit delay wrong");
   chk_flag_clear: assert property (@(posedge core_clk) disable iff (!arst_n)
      (wrEn && idx == IDX_STATUS && pwdata[ST_FLAG] && !(unfrozen && compRun && edgeHit)) |=> !flag_r) // see RULE12
      else $error("flag not cleared by one");
   chk_irq_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
      (unfrozen && flag_r && irqEn_r[IRQ_CMP] && !wrEn) |=> irq)                 // see RULE14 see RULE10
      else $error("request dropped while flag set");
   chk_power_down: assert property (@(posedge core_clk) disable iff (!arst_n)
      powerMode == PWR_DOWN |=> padOe_n && !analogCtl.enable)                    // see RULE16
      else $error("active in power-down");

   // ===================================================
   // register bank checks
   // every writable register and the flag come out of reset cleared
   chk_reset_rest: assert property (@(posedge core_clk) $rose(arst_n) |-> // see RULE1
      sel_r == RESET_VAL && irqEn_r == RESET_VAL && !flag_r)
      else $error("registers not zero after reset");
   // zero wait states: ready follows every setup cycle
   chk_pready_setup: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE17
      (psel && !penable) |=> pready)
      else $error("no ready after setup");
   // ready never stands outside an access phase
   chk_pready_idle: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE17
      !(psel && !penable) |=> !pready)
      else $error("ready without setup");
   // control write lands with unused bits dropped
   chk_ctl_write: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE1 see RULE17
      (wrEn && idx == IDX_CONTROL) |=> ctl_r == ($past(pwdata[7:0]) & CTL_MASK))
      else $error("control write lost");
   // input select write lands with unused bits dropped
   chk_sel_write: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE17
      (wrEn && idx == IDX_INSEL) |=> sel_r == ($past(pwdata[7:0]) & SEL_MASK))
      else $error("input select write lost");
   // irq enable write lands with unused bits dropped
   chk_irqen_write: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE10 see RULE17
      (wrEn && idx == IDX_IRQEN) |=> irqEn_r == ($past(pwdata[7:0]) & IRQ_MASK))
      else $error("irq enable write lost");
   // unused bit positions can never hold a one
   chk_unused_zero: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE17
      (ctl_r & ~CTL_MASK) == 8'h00 && (sel_r & ~SEL_MASK) == 8'h00 && (irqEn_r & ~IRQ_MASK) == 8'h00)
      else $error("unused bit set");
   // status read returns flag and synchronized state
   chk_read_status: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE11 see RULE12
      (rdEn && idx == IDX_STATUS) |=> prdata[ST_FLAG] == $past(flag_r) && prdata[ST_STATE] == $past(curState))
      else $error("status read wrong");
   // holes in the map read as zero
   chk_read_rsvd: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE17
      (rdEn && idx != IDX_CONTROL && idx != IDX_INSEL && idx != IDX_IRQEN && idx != IDX_STATUS)
      |=> prdata == 32'h0000_0000)
      else $error("reserved offset not zero");

   // ===================================================
   // edge and flag checks
   // a rising edge may not set the flag in falling mode
   chk_fall_only: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE5
      (mode == MODE_FALL && !prevState_r && curState && !flag_r) |=> !flag_r)
      else $error("rising edge set flag in fall mode");
   // the reserved mode code is inert
   chk_rsvd_mode: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE5
      (mode == MODE_RSVD && !flag_r) |=> !flag_r)
      else $error("reserved mode set flag");
   // any change sets the flag in any-edge mode
   chk_any_edge: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE13
      (unfrozen && compRun && mode == MODE_ANY && curState != prevState_r) |=> flag_r)
      else $error("edge missed in any mode");
   // rising edge sets the flag in rise mode
   chk_rise_sets: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE13
      (unfrozen && compRun && mode == MODE_RISE && !prevState_r && curState) |=> flag_r)
      else $error("rising edge missed");
   // falling edge sets the flag in fall mode
   chk_fall_sets: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE13
      (unfrozen && compRun && mode == MODE_FALL && prevState_r && !curState) |=> flag_r)
      else $error("falling edge missed");
   // an edge in the clearing cycle must not be lost
   chk_set_wins: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE12 see RULE13
      (wrEn && idx == IDX_STATUS && pwdata[ST_FLAG] && unfrozen && compRun && edgeHit) |=> flag_r)
      else $error("edge lost against clear");
   // writing zero leaves the flag alone
   chk_clear_zero: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE12
      (wrEn && idx == IDX_STATUS && !pwdata[ST_FLAG] && flag_r) |=> flag_r)
      else $error("flag cleared by zero");
   // previous sample tracks the synchronized state
   chk_prev_track: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE18
      unfrozen |=> prevState_r == $past(curState))
      else $error("previous sample stale");
   // synchronized state holds while the clock is stopped
   chk_frozen_sync: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE3
      !unfrozen |=> $stable(curState))
      else $error("state moved with clock stopped");
   // a halted comparator drains the synchronizer to zero
   chk_state_off: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE11
      (unfrozen && !compRun)[*4] |-> !curState)
      else $error("state stuck while halted");

   // ===================================================
   // request, pad and analog control checks
   // request only stands on a live enabled flag
   chk_irq_source: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE10 see RULE14
      (irq && $past(unfrozen)) |-> flag_r && irqEn_r[IRQ_CMP])
      else $error("request without enabled flag");
   // disabled source keeps the request low
   chk_irq_gate: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE10
      (unfrozen && !irqEn_r[IRQ_CMP] && !(wrEn && idx == IDX_IRQEN)) |=> !irq)
      else $error("request while disabled");
   // pad is driven with the polarity-corrected output
   chk_pad_on: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE4 see RULE7
      (compRun && ctl_r[CTL_PADEN]) |=> !padOe_n && padOut == $past(polOut))
      else $error("pad not driven");
   // a halted comparator releases and clears the pad
   chk_pad_halt: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE16
      !compRun |=> padOe_n && !padOut)
      else $error("pad active while halted");
   // event output follows the corrected comparator output
   chk_event_follow: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE7
      1'b1 |=> compareEvent == $past(compRun && polOut))
      else $error("event output wrong");
   // power-down silences the event output too
   chk_down_event: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE16
      powerMode == PWR_DOWN |=> !compareEvent && !padOut)
      else $error("event active in power-down");
   // input selects reach the analog core one cycle later
   chk_mux_pass: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE8 see RULE9
      1'b1 |=> analogCtl.posSel == $past(sel_r[SEL_POS]) && analogCtl.negSel == $past(sel_r[SEL_NEG_LO +: 2]))
      else $error("input select not presented");
   // enable bit runs the comparator in active mode
   chk_enable_run: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE1
      (ctl_r[CTL_ENABLE] && powerMode == PWR_ACTIVE) |=> analogCtl.enable)
      else $error("comparator not running");
   // standby run bit keeps the comparator alive
   chk_standby_run: assert property (@(posedge core_clk) disable iff (!arst_n) // see RULE2
      (ctl_r[CTL_ENABLE] && ctl_r[CTL_STBYRUN] && powerMode == PWR_STANDBY) |=> analogCtl.enable)
      else $error("comparator halted in standby run");
endmodule

// file: analog_comparator_model.sv
// behavioural model of the analog comparator core and its input multiplexers
`timescale 1ns/1ps
module analog_comparator_model
   import comparator_pkg::*;
(
   // controls from the block
   input wire comparator_pkg::analog_ctl_s analogCtl,
   // levels in mV: 0,1 positive pins, 2,3 negative pins, 4 reference
   input wire logic [4:0][11:0] pinMv,
   // raw decision
   output logic rawCompare
);
   int posMv, negMv, hysMv;
   // the core keeps deciding while disabled, so the block itself must mask it
   always @* begin
      posMv = int'(pinMv[analogCtl.posSel]);
      negMv = analogCtl.negSel[1] ? int'(pinMv[4]) : int'(pinMv[2 + analogCtl.negSel[0]]);
      case (analogCtl.hysteresis)
         2'h0: hysMv = 0;
         2'h1: hysMv = 10;
         2'h2: hysMv = 25;
         default: hysMv = 50;
      endcase
      // inside the dead band the last decision holds
      if (posMv > negMv + hysMv) rawCompare = 1'b1;
      else if (posMv + hysMv <= negMv) rawCompare = 1'b0;
   end
endmodule

// file: comparator_control_regs_tb.sv
// self-checking testbench of the comparator control register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin fails++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module comparator_control_regs_tb;
   import comparator_pkg::*;
   logic core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, perClkStopped = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, seed = 32'h4771;
   logic pready, pslverr, rawCompare, padOut, padOe_n, compareEvent, irq, fr;
   power_mode_e powerMode = PWR_ACTIVE;
   analog_ctl_s analogCtl;
   edge_mode_e modes [4] = '{MODE_ANY, MODE_FALL, MODE_RISE, MODE_RSVD};
   logic [4:0][11:0] pinMv = '0;
   logic [7:0] v, expQ[$];
   int fails = 0, numChecks = 0;
   // ==========================================
   // design, analog partner and clock
   comparator_control_regs u_dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rawCompare(rawCompare), .powerMode(powerMode), .perClkStopped(perClkStopped),
      .analogCtl(analogCtl), .padOut(padOut), .padOe_n(padOe_n), .compareEvent(compareEvent), .irq(irq));
   analog_comparator_model u_core (.analogCtl(analogCtl), .pinMv(pinMv), .rawCompare(rawCompare));
   always #10 core_clk = ~core_clk;
   // ==========================================
   // helpers
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", numChecks, fails);
      if (fails == 0 && numChecks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one apb transfer; the request holds until pready is seen at a rising edge
   task automatic apb(input logic wr, input logic [2:0] idx, input logic [7:0] d);
      logic ok;
      ok = 1'b0;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h000000, d};
      @(posedge core_clk);
      penable <= 1'b1;
      for (int n = 0; n < 16 && !ok; n++) begin
         @(posedge core_clk);
         ok = (pready === 1'b1);
      end
      psel <= 1'b0;
      penable <= 1'b0;
      if (!ok) begin
         fails++;
         close_out();
      end
   endtask
   task automatic rd(input logic [2:0] idx, input logic [7:0] e);
      expQ.push_back(e);
      apb(1'b0, idx, 8'(xs()));
   endtask
   // the synchronizer plus flag and readback need a few edges
   task automatic settle();
      repeat (SYNC_STAGES + 3) @(posedge core_clk);
   endtask
   // read results are compared against the oldest pending note
   always @(posedge core_clk) begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
         `CHK("prdata", {24'h000000, expQ[0]}, prdata)
         void'(expQ.pop_front());
      end
   end
   // ==========================================
   // main sequence
   initial begin
      repeat (4) @(posedge core_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 8; i++) rd(3'(i), 8'h00);
      $display("reset values done");
      for (int i = 0; i < 7; i++) begin
         v = 8'(xs());
         apb(1'b1, 3'(i), v);
         rd(3'(i), v & (i == 0 ? CTL_MASK : i == 2 ? SEL_MASK : i == 6 ? IRQ_MASK : 8'h00));
      end
      $display("register access done");
      for (int h = 0; h < 4; h++) begin
         apb(1'b1, IDX_CONTROL, 8'(h * 2 + 1));
         apb(1'b1, IDX_INSEL, 8'((h % 2) * 8 + h % 3));
         repeat (2) @(negedge core_clk);
         `CHK("analogCtl", analog_ctl_s'({1'b1, 2'(h), 1'(h % 2), 2'(h % 3)}), analogCtl)
      end
      apb(1'b1, IDX_CONTROL, 8'h00);
      apb(1'b1, IDX_INSEL, 8'h00);
      settle();
      apb(1'b1, IDX_STATUS, 8'h01);
      apb(1'b1, IDX_IRQEN, 8'h01);
      $display("analog controls done");
      foreach (modes[k]) begin
         apb(1'b1, IDX_CONTROL, {2'h0, modes[k], 4'h1});
         pinMv[0] <= 12'h100;
         settle();
         fr = (modes[k] == MODE_ANY || modes[k] == MODE_RISE);
         rd(IDX_STATUS, {7'h08, fr});
         @(negedge core_clk);
         `CHK("irq", fr, irq)
         apb(1'b1, IDX_STATUS, 8'h00);
         rd(IDX_STATUS, {7'h08, fr});
         apb(1'b1, IDX_STATUS, 8'h01);
         pinMv[0] <= 12'h000;
         settle();
         fr = (modes[k] == MODE_ANY || modes[k] == MODE_FALL);
         rd(IDX_STATUS, {7'h00, fr});
         apb(1'b1, IDX_STATUS, 8'h01);
      end
      $display("edge modes done");
      apb(1'b1, IDX_IRQEN, 8'h00);
      apb(1'b1, IDX_CONTROL, 8'h71);
      apb(1'b1, IDX_INSEL, 8'h80);
      settle();
      rd(IDX_STATUS, 8'h11);
      @(negedge core_clk);
      `CHK("irq", 1'b0, irq)
      `CHK("padOe_n", 1'b0, padOe_n)
      `CHK("padOut", 1'b1, padOut)
      `CHK("compareEvent", 1'b1, compareEvent)
      apb(1'b1, IDX_IRQEN, 8'h01);
      repeat (2) @(negedge core_clk);
      `CHK("irq", 1'b1, irq)
      $display("invert and gating done");
      apb(1'b1, IDX_STATUS, 8'h01);
      apb(1'b1, IDX_CONTROL, 8'hF1);
      powerMode <= PWR_STANDBY;
      perClkStopped <= 1'b1;
      pinMv[0] <= 12'h100;
      settle();
      pinMv[0] <= 12'h000;
      settle();
      @(negedge core_clk);
      `CHK("irq", 1'b0, irq)
      `CHK("padOut", 1'b1, padOut)
      perClkStopped <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, IDX_CONTROL, k == 0 ? 8'h71 : 8'hF1);
         powerMode <= (k == 0) ? PWR_STANDBY : PWR_DOWN;
         repeat (2) @(negedge core_clk);
         `CHK("enable", 1'b0, analogCtl.enable)
         `CHK("padOe_n", 1'b1, padOe_n)
      end
      $display("sleep modes done");
      close_out();
   end
endmodule
